/* verilog/tbc_top.sv */
`timescale 1ns/1ps
module tbc_top (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic hsel_reg_in,
  input wire logic hsel_ram_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [3:0] hprot_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic ram_en_out,
  output logic ram_we_out,
  output logic [tbc_pkg::RAM_AW-1:0] ram_addr_out,
  output logic [tbc_pkg::WORD_W-1:0] ram_wdata_out,
  input wire logic [tbc_pkg::WORD_W-1:0] ram_rdata_in,
  input wire logic trace_valid_in,
  input wire logic [tbc_pkg::PKT_W-1:0] trace_data_in,
  output logic trace_ready_out,
  input wire logic trace_start_input_in,
  input wire logic trace_stop_input_in,
  input wire logic invasive_debug_enable_in,
  output logic debug_halt_request_out
);
  import tbc_pkg::*;

  tbc_stream_if pk ();
  tbc_bus_st_t bus_st_q, bus_st_d;
  tbc_wr_st_t wr_st_q, wr_st_d;
  logic ap_valid_q, ap_valid_d, ap_write_q, ap_write_d;
  logic ap_ram_q, ap_ram_d, ap_priv_q, ap_priv_d;
  logic [11:0] ap_ofs_q, ap_ofs_d;
  logic [RAM_AW-1:0] ap_raddr_q, ap_raddr_d;
  logic [31:0] hrdata_q, hrdata_d, reg_rdata;
  logic hready_q, hready_d;
  logic [31:0] master_q, master_d, flow_q, flow_d;
  logic [PTR_W-1:0] ptr_q, ptr_d, next_ptr, keep;
  logic wrap_q, wrap_d, wrap_hit, wm_block_q, wm_block_d, dbg_req_q, dbg_req_d;
  logic ram_en_q, ram_en_d, ram_we_q, ram_we_d, bus_we_q, bus_we_d;
  logic [RAM_AW-1:0] ram_addr_q, ram_addr_d;
  logic [WORD_W-1:0] ram_wdata_q, ram_wdata_d;
  logic addr_take, priv_req, dp_reg_wr, dp_ram_wr, sw_pos_wr;
  logic bus_claim, wr_go, step, wm_match;

  tbc_skid_buf u_buf (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .valid_in(trace_valid_in),
    .data_in(trace_data_in),
    .ready_out(trace_ready_out),
    .out(pk)
  );

  tbc_ptr_step u_step (
    .ptr_in(ptr_q),
    .mask_in(master_q[MST_MASK_LSB +: MASK_W]),
    .next_out(next_ptr),
    .wrap_out(wrap_hit),
    .keep_out(keep)
  );

  assign addr_take = hready_in & htrans_in[1] & (hsel_reg_in | hsel_ram_in);
  assign priv_req = hprot_in[HPROT_PRIV];
  assign dp_reg_wr = ap_valid_q & ap_write_q & ~ap_ram_q
                   & (ap_priv_q | ~master_q[MST_WPRIV]);
  assign dp_ram_wr = ap_valid_q & ap_write_q & ap_ram_q
                   & (ap_priv_q | ~master_q[MST_RAM_PRIV]);
  assign sw_pos_wr = dp_reg_wr & (ap_ofs_q == OFS_POSITION);
  assign bus_claim = dp_ram_wr | (bus_st_q == B_RD1);
  assign wr_go = ~bus_claim & ((wr_st_q == W_LO) | (wr_st_q == W_HI));
  assign step = (wr_st_q == W_HI) & wr_go;
  // watermark and pointer share the address-bits-31:3 format
  assign wm_match = ({{(32 - FLOW_WM_LSB - PTR_W){1'b0}}, ptr_q}
                    == flow_q[31:FLOW_WM_LSB]);
  // trace packets are drained and dropped while tracing is off
  assign pk.ready = step | ((wr_st_q == W_IDLE) & ~master_q[MST_EN]);

  always_comb
  begin
    case (haddr_in[11:0])
      OFS_POSITION: reg_rdata = {{(32 - POS_PTR_LSB - PTR_W){1'b0}}, ptr_q, wrap_q, 2'h0};
      OFS_MASTER: reg_rdata = master_q;
      OFS_FLOW: reg_rdata = flow_q;
      OFS_BASE: reg_rdata = TRACE_BASE;
      default: reg_rdata = HARDWIRED;
    endcase
  end

  // bus slave: address capture, read data and RAM read wait states
  always_comb
  begin
    ap_valid_d = addr_take & (bus_st_q == B_IDLE);
    ap_write_d = ap_write_q;
    ap_ram_d = ap_ram_q;
    ap_priv_d = ap_priv_q;
    ap_ofs_d = ap_ofs_q;
    ap_raddr_d = ap_raddr_q;
    hrdata_d = hrdata_q;
    hready_d = 1'b1;
    bus_st_d = bus_st_q;
    case (bus_st_q)
      B_IDLE:
      begin
        if (addr_take)
        begin
          ap_write_d = hwrite_in;
          ap_ram_d = hsel_ram_in;
          ap_priv_d = priv_req;
          ap_ofs_d = haddr_in[11:0];
          ap_raddr_d = haddr_in[RAM_AW+1:2];
          if (!hwrite_in && hsel_ram_in)
          begin
            if (priv_req || !master_q[MST_RAM_PRIV])
            begin
              bus_st_d = B_RD1;
              hready_d = 1'b0;
            end
            else
            begin
              hrdata_d = HARDWIRED;
            end
          end
          else if (!hwrite_in)
          begin
            hrdata_d = reg_rdata;
          end
        end
      end
      B_RD1:
      begin
        bus_st_d = B_RD2;
        hready_d = 1'b0;
      end
      B_RD2:
      begin
        bus_st_d = B_RD3;
        hready_d = 1'b0;
      end
      B_RD3:
      begin
        hrdata_d = ram_rdata_in;
        bus_st_d = B_IDLE;
      end
      default:
      begin
        bus_st_d = B_IDLE;
      end
    endcase
  end

  // RAM port: bus accesses take precedence over trace writes
  always_comb
  begin
    ram_en_d = 1'b0;
    ram_we_d = 1'b0;
    bus_we_d = 1'b0;
    ram_addr_d = ram_addr_q;
    ram_wdata_d = ram_wdata_q;
    wr_st_d = wr_st_q;
    if (dp_ram_wr)
    begin
      ram_en_d = 1'b1;
      ram_we_d = 1'b1;
      bus_we_d = 1'b1;
      ram_addr_d = ap_raddr_q;
      ram_wdata_d = hwdata_in;
    end
    else if (bus_st_q == B_RD1)
    begin
      ram_en_d = 1'b1;
      ram_addr_d = ap_raddr_q;
    end
    else if (wr_go)
    begin
      ram_en_d = 1'b1;
      ram_we_d = 1'b1;
      ram_addr_d = {ptr_q, (wr_st_q == W_HI)};
      ram_wdata_d = (wr_st_q == W_HI) ? pk.data[63:32] : pk.data[31:0];
    end
    case (wr_st_q)
      W_IDLE:
      begin
        if (pk.valid && master_q[MST_EN])
        begin
          wr_st_d = W_LO;
        end
      end
      W_LO:
      begin
        if (wr_go)
        begin
          wr_st_d = W_HI;
        end
      end
      W_HI:
      begin
        // a started packet ends even if tracing stopped meanwhile
        if (wr_go)
        begin
          wr_st_d = W_IDLE;
        end
      end
      default:
      begin
        wr_st_d = W_IDLE;
      end
    endcase
  end

  // control registers and their hardware updates
  always_comb
  begin
    master_d = master_q;
    flow_d = flow_q;
    ptr_d = ptr_q;
    wrap_d = wrap_q;
    wm_block_d = wm_block_q;
    if (step)
    begin
      ptr_d = next_ptr;
    end
    if (dp_reg_wr)
    begin
      case (ap_ofs_q)
        OFS_MASTER: master_d = hwdata_in & MASTER_WMASK;
        OFS_FLOW:
        begin
          flow_d = hwdata_in & FLOW_WMASK;
          wm_block_d = 1'b0;
        end
        OFS_POSITION:
        begin
          ptr_d = hwdata_in[POS_PTR_LSB +: PTR_W];
          wrap_d = hwdata_in[POS_WRAP];
          wm_block_d = 1'b0;
        end
        default: ;
      endcase
    end
    if (step && wrap_hit)
    begin
      wrap_d = 1'b1;
    end
    if (master_q[MST_STARTEN] && trace_start_input_in && !wm_block_q)
    begin
      master_d[MST_EN] = 1'b1;
    end
    if (master_q[MST_STOPEN] && trace_stop_input_in)
    begin
      master_d[MST_EN] = 1'b0;
    end
    if (flow_q[FLOW_AUTOSTOP] && wm_match)
    begin
      master_d[MST_EN] = 1'b0;
      if (master_q[MST_EN])
      begin
        wm_block_d = 1'b1;
      end
    end
    if (flow_q[FLOW_AUTOHALT] && wm_match)
    begin
      master_d[MST_HALT] = 1'b1;
    end
    dbg_req_d = master_q[MST_HALT] & invasive_debug_enable_in;
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      bus_st_q <= B_IDLE;
      wr_st_q <= W_IDLE;
      ap_valid_q <= 1'b0;
      ap_write_q <= 1'b0;
      ap_ram_q <= 1'b0;
      ap_priv_q <= 1'b0;
      ap_ofs_q <= 12'h000;
      ap_raddr_q <= '0;
      hrdata_q <= 32'h0000_0000;
      hready_q <= 1'b1;
      master_q <= MASTER_RST;
      flow_q <= FLOW_RST;
      ptr_q <= PTR_RST;
      wrap_q <= 1'b0;
      wm_block_q <= 1'b0;
      dbg_req_q <= 1'b0;
      ram_en_q <= 1'b0;
      ram_we_q <= 1'b0;
      bus_we_q <= 1'b0;
      ram_addr_q <= '0;
      ram_wdata_q <= 32'h0000_0000;
    end
    else
    begin
      bus_st_q <= bus_st_d;
      wr_st_q <= wr_st_d;
      ap_valid_q <= ap_valid_d;
      ap_write_q <= ap_write_d;
      ap_ram_q <= ap_ram_d;
      ap_priv_q <= ap_priv_d;
      ap_ofs_q <= ap_ofs_d;
      ap_raddr_q <= ap_raddr_d;
      hrdata_q <= hrdata_d;
      hready_q <= hready_d;
      master_q <= master_d;
      flow_q <= flow_d;
      ptr_q <= ptr_d;
      wrap_q <= wrap_d;
      wm_block_q <= wm_block_d;
      dbg_req_q <= dbg_req_d;
      ram_en_q <= ram_en_d;
      ram_we_q <= ram_we_d;
      bus_we_q <= bus_we_d;
      ram_addr_q <= ram_addr_d;
      ram_wdata_q <= ram_wdata_d;
    end
  end

  assign hrdata_out = hrdata_q;
  assign hreadyout_out = hready_q;
  assign ram_en_out = ram_en_q;
  assign ram_we_out = ram_we_q;
  assign ram_addr_out = ram_addr_q;
  assign ram_wdata_out = ram_wdata_q;
  assign debug_halt_request_out = dbg_req_q;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  a_user_ram_rd: assert property ((bus_st_q == B_IDLE) && addr_take && hsel_ram_in && !hwrite_in
    && !priv_req && master_q[MST_RAM_PRIV] |=> hrdata_out == 32'h0 && hreadyout_out)
    else $error("user RAM read not zero");
  a_user_ram_wr: assert property (ap_valid_q && ap_write_q && ap_ram_q && !ap_priv_q
    && master_q[MST_RAM_PRIV] |=> !bus_we_q)
    else $error("user RAM write reached RAM");
  a_priv_ram_rd: assert property ((bus_st_q == B_IDLE) && addr_take && hsel_ram_in
    && !hwrite_in && priv_req |=> !hreadyout_out [*3] ##1 hreadyout_out)
    else $error("privileged RAM read timing wrong");
  a_user_reg_wr: assert property (ap_valid_q && ap_write_q && !ap_ram_q && !ap_priv_q
    && master_q[MST_WPRIV] |=> $stable(flow_q))
    else $error("user register write accepted");
  a_base_read: assert property ((bus_st_q == B_IDLE) && addr_take && !hsel_ram_in
    && !hwrite_in && haddr_in[11:0] == OFS_BASE |=> hrdata_out == TRACE_BASE)
    else $error("base register read wrong");
  a_stop_input: assert property (master_q[MST_STOPEN] && trace_stop_input_in
    |=> !master_q[MST_EN])
    else $error("stop input did not clear enable");
  a_start_input: assert property (master_q[MST_STARTEN] && trace_start_input_in
    && !wm_block_q && !(master_q[MST_STOPEN] && trace_stop_input_in)
    && !(flow_q[FLOW_AUTOSTOP] && wm_match) && !dp_reg_wr |=> master_q[MST_EN])
    else $error("start input did not set enable");
  a_wrap_set: assert property (step && wrap_hit |=> wrap_q)
    else $error("wrap flag not set");
  a_ptr_high: assert property (step && !sw_pos_wr
    |=> (ptr_q & $past(keep)) == ($past(ptr_q) & $past(keep)))
    else $error("pointer bits above mask changed");
  a_halt_out: assert property (master_q[MST_HALT] && invasive_debug_enable_in
    |=> debug_halt_request_out)
    else $error("halt request not driven");
  a_halt_gate: assert property (!invasive_debug_enable_in |=> !debug_halt_request_out)
    else $error("halt request without debug enable");
  a_auto_stop: assert property (flow_q[FLOW_AUTOSTOP] && wm_match && master_q[MST_EN]
    |=> !master_q[MST_EN] && wm_block_q)
    else $error("watermark stop failed");
  a_flow_rsvd: assert property (flow_q[FLOW_RSVD] == 1'b0)
    else $error("flow reserved bit set");
  c_wrap: cover property (step && wrap_hit);
  c_auto_stop: cover property (flow_q[FLOW_AUTOSTOP] && wm_match && master_q[MST_EN]);
  c_halt: cover property ($rose(debug_halt_request_out));
  c_ram_read: cover property (bus_st_q == B_RD3);
endmodule

/* verilog/tbc_pkg.sv */
// Operation
// - privilege-only bit blocks user trace RAM access
// - user or privileged taken from protection bit
// - write-privilege bit drops user register writes
// - register reads always succeed
// - enabled stop input clears trace enable
// - packet write in progress completes first
// - enabled start input sets trace enable
// - mask limits increment, wrap sets flag
// - circular region of 2^(mask+4) bytes
// - mask above eleven acts as eleven
// - watermark compared with pointer for actions
// - auto-halt sets halt bit, gated out
// - auto-stop clears trace enable on match
// - flow bit 2 reads zero, ignores writes
// - base register returns anchor minus quarter RAM
// - discovery registers hardwired to zero
// - enabled packets written then pointer incremented
// - pointer holds address bits 31:3
// - start blocked after watermark stop until rewrite
package tbc_pkg;
  localparam int PTR_W = 12;
  localparam int RAM_AW = 13;
  localparam int WORD_W = 32;
  localparam int PKT_W = 64;
  localparam int MASK_W = 5;
  localparam int HPROT_PRIV = 1;
  localparam logic [11:0] OFS_POSITION = 12'h000;
  localparam logic [11:0] OFS_MASTER = 12'h004;
  localparam logic [11:0] OFS_FLOW = 12'h008;
  localparam logic [11:0] OFS_BASE = 12'h00c;
  localparam logic [11:0] OFS_MODECTRL = 12'hf00;
  localparam logic [11:0] OFS_TAGSET = 12'hfa0;
  localparam logic [11:0] OFS_TAGCLEAR = 12'hfa4;
  localparam logic [11:0] OFS_LOCKACCESS = 12'hfb0;
  localparam int MST_EN = 31;
  localparam int MST_HALT = 9;
  localparam int MST_RAM_PRIV = 8;
  localparam int MST_WPRIV = 7;
  localparam int MST_STOPEN = 6;
  localparam int MST_STARTEN = 5;
  localparam int MST_MASK_LSB = 0;
  localparam logic [MASK_W-1:0] MASK_MAX = 5'h0b;
  localparam int FLOW_WM_LSB = 3;
  localparam int FLOW_RSVD = 2;
  localparam int FLOW_AUTOHALT = 1;
  localparam int FLOW_AUTOSTOP = 0;
  localparam int POS_PTR_LSB = 3;
  localparam int POS_WRAP = 2;
  localparam logic [31:0] MASTER_RST = 32'h0000_0000;
  localparam logic [31:0] FLOW_RST = 32'h0000_0000;
  localparam logic [PTR_W-1:0] PTR_RST = 12'h000;
  localparam logic [31:0] MASTER_WMASK = 32'h8000_03ff;
  localparam logic [31:0] FLOW_WMASK = 32'hffff_fffb;
  localparam logic [31:0] RAM_SIZE_BYTES = 32'h0000_4000;
  localparam logic [31:0] BASE_ANCHOR = 32'h2000_0000;
  localparam logic [31:0] TRACE_BASE = BASE_ANCHOR - (RAM_SIZE_BYTES >> 2);
  localparam logic [31:0] HARDWIRED = 32'h0000_0000;
  typedef enum logic [3:0] {B_IDLE = 4'h1, B_RD1 = 4'h2, B_RD2 = 4'h4, B_RD3 = 4'h8} tbc_bus_st_t;
  typedef enum logic [2:0] {W_IDLE = 3'h1, W_LO = 3'h2, W_HI = 3'h4} tbc_wr_st_t;
endpackage

/* verilog/tbc_stream_if.sv */
`timescale 1ns/1ps
interface tbc_stream_if;
  logic valid;
  logic ready;
  logic [tbc_pkg::PKT_W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* verilog/tbc_ptr_step.sv */
`timescale 1ns/1ps
module tbc_ptr_step (
  input wire logic [tbc_pkg::PTR_W-1:0] ptr_in,
  input wire logic [tbc_pkg::MASK_W-1:0] mask_in,
  output logic [tbc_pkg::PTR_W-1:0] next_out,
  output logic wrap_out,
  output logic [tbc_pkg::PTR_W-1:0] keep_out
);
  import tbc_pkg::*;
  logic [MASK_W-1:0] eff;
  logic [PTR_W-1:0] low_mask;
  logic [PTR_W-1:0] inc;
  assign eff = (mask_in > MASK_MAX) ? MASK_MAX : mask_in;
  genvar i;
  generate
    for (i = 0; i < PTR_W; i++)
    begin : g_mask
      // region of 2^(eff+4) bytes is 2^(eff+1) packets
      assign low_mask[i] = (5'(i) <= eff);
    end
  endgenerate
  assign inc = (ptr_in & low_mask) + 12'h001;
  assign next_out = (inc & low_mask) | (ptr_in & ~low_mask);
  assign wrap_out = ((ptr_in & low_mask) == low_mask);
  assign keep_out = ~low_mask;
endmodule

/* verilog/tbc_skid_buf.sv */
`timescale 1ns/1ps
module tbc_skid_buf (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic valid_in,
  input wire logic [tbc_pkg::PKT_W-1:0] data_in,
  output logic ready_out,
  tbc_stream_if.src out
);
  import tbc_pkg::*;
  logic [PKT_W-1:0] mem_q [2];
  logic [PKT_W-1:0] mem_d [2];
  logic [1:0] cnt_q, cnt_d;
  logic wr_q, wr_d, rd_q, rd_d, rdy_q, rdy_d;
  logic push, pop;
  assign push = valid_in & rdy_q;
  assign pop = out.valid & out.ready;
  assign out.valid = (cnt_q != 2'h0);
  assign out.data = mem_q[rd_q];
  assign ready_out = rdy_q;
  always_comb
  begin
    for (int k = 0; k < 2; k++)
    begin
      mem_d[k] = (push && (wr_q == 1'(k))) ? data_in : mem_q[k];
    end
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    wr_d = wr_q ^ push;
    rd_d = rd_q ^ pop;
    rdy_d = (cnt_d != 2'h2);
  end
  always_ff @(posedge clock_in)
  begin
    mem_q <= mem_d;
    if (sys_rst_in)
    begin
      cnt_q <= 2'h0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      rdy_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      rdy_q <= rdy_d;
    end
  end
endmodule

/* test/tbc_ram_model.sv */
`timescale 1ns/1ps
// synchronous trace ram standing behind the block's ram port
module tbc_ram_model
  import tbc_pkg::*;
(
  input wire logic clock_in,
  input wire logic en_in,
  input wire logic we_in,
  input wire logic [RAM_AW-1:0] addr_in,
  input wire logic [WORD_W-1:0] wdata_in,
  output logic [WORD_W-1:0] rdata_out
);
  logic [WORD_W-1:0] mem [0:(1<<RAM_AW)-1];
  // outside a read cycle the data lines toggle so stale data never looks valid
  always_ff @(posedge clock_in)
  begin
    if (en_in && we_in)
      mem[addr_in] <= wdata_in;
    if (en_in && !we_in)
      rdata_out <= mem[addr_in];
    else
      rdata_out <= ~rdata_out;
  end
endmodule

/* test/trace_buffer_control_test.sv */
`timescale 1ns/1ps
module trace_buffer_control_test;
  import tbc_pkg::*;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic hsel_reg_in = 1'b0, hsel_ram_in = 1'b0, hwrite_in = 1'b0;
  logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, hrdata_out, r;
  logic [1:0] htrans_in = 2'h0;
  logic [3:0] hprot_in = 4'h3;
  logic hreadyout_out, ram_en_out, ram_we_out, trace_ready_out, halt_out;
  logic [RAM_AW-1:0] ram_addr_out;
  logic [WORD_W-1:0] ram_wdata_out, ram_rdata_in;
  logic trace_valid_in = 1'b0, start_in = 1'b0, stop_in = 1'b0, dbg_en = 1'b0;
  logic [PKT_W-1:0] trace_data_in = 64'h0;
  int fail_count = 0;
  int check_count = 0;
  int waits = 0;

  always #12.5 clock_in = ~clock_in;

  tbc_top u_dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .hsel_reg_in(hsel_reg_in),
    .hsel_ram_in(hsel_ram_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
    .hwrite_in(hwrite_in), .hprot_in(hprot_in), .hwdata_in(hwdata_in),
    .hready_in(hreadyout_out), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
    .ram_en_out(ram_en_out), .ram_we_out(ram_we_out), .ram_addr_out(ram_addr_out),
    .ram_wdata_out(ram_wdata_out), .ram_rdata_in(ram_rdata_in),
    .trace_valid_in(trace_valid_in), .trace_data_in(trace_data_in),
    .trace_ready_out(trace_ready_out), .trace_start_input_in(start_in),
    .trace_stop_input_in(stop_in), .invasive_debug_enable_in(dbg_en),
    .debug_halt_request_out(halt_out));

  tbc_ram_model u_ram (.clock_in(clock_in), .en_in(ram_en_out), .we_in(ram_we_out),
    .addr_in(ram_addr_out), .wdata_in(ram_wdata_out), .rdata_out(ram_rdata_in));

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic ram, input logic wr, input logic priv,
                     input logic [31:0] addr, input logic [31:0] wdata, output logic [31:0] rd);
    int n;
    n = 0;
    @(negedge clock_in);
    hsel_reg_in = !ram;
    hsel_ram_in = ram;
    hwrite_in = wr;
    hprot_in = priv ? 4'h3 : 4'h1;
    haddr_in = addr;
    htrans_in = 2'h2;
    @(negedge clock_in);
    hsel_reg_in = 1'b0;
    hsel_ram_in = 1'b0;
    htrans_in = 2'h0;
    hwdata_in = wdata;
    while (hreadyout_out !== 1'b1 && n < 20)
    begin
      @(negedge clock_in);
      n++;
    end
    waits = n;
    if (n >= 20)
      fail_count++;
    rd = hrdata_out;
  endtask

  task automatic wreg(input logic [11:0] ofs, input logic [31:0] d, input logic priv = 1'b1);
    logic [31:0] x;
    bus(1'b0, 1'b1, priv, {20'h0, ofs}, d, x);
  endtask

  task automatic rreg(input logic [11:0] ofs, output logic [31:0] d, input logic priv = 1'b1);
    bus(1'b0, 1'b0, priv, {20'h0, ofs}, 32'h0, d);
  endtask

  task automatic send(input logic [63:0] d);
    int n;
    n = 0;
    @(negedge clock_in);
    trace_valid_in = 1'b1;
    trace_data_in = d;
    while (trace_ready_out !== 1'b1 && n < 50)
    begin
      @(negedge clock_in);
      n++;
    end
    @(negedge clock_in);
    if (n >= 50)
      fail_count++;
    trace_valid_in = 1'b0;
    repeat (12) @(negedge clock_in);
  endtask

  task automatic test_hardwired();
    logic [11:0] ofs [5] = '{OFS_MODECTRL, OFS_TAGSET, OFS_TAGCLEAR, OFS_LOCKACCESS, 12'h800};
    rreg(OFS_BASE, r);
    check("base", r, 32'h1fff_f000);
    foreach (ofs[i])
    begin
      wreg(ofs[i], 32'hffff_ffff);
      rreg(ofs[i], r);
      check("hardwired", r, 32'h0000_0000);
    end
    wreg(OFS_FLOW, 32'hffff_ffff);
    rreg(OFS_FLOW, r);
    check("flow mask", r, 32'hffff_fffb);
    wreg(OFS_FLOW, 32'h0);
    wreg(OFS_MASTER, 32'h7fff_fc00);
    rreg(OFS_MASTER, r);
    check("master reserved", r, 32'h0000_0000);
    $display("done hardwired");
  endtask

  task automatic test_privilege();
    wreg(OFS_MASTER, 32'h0000_0080);
    wreg(OFS_FLOW, 32'h0000_0008, 1'b0);
    rreg(OFS_FLOW, r, 1'b0);
    check("user write dropped", r, 32'h0);
    wreg(OFS_FLOW, 32'h0000_0008);
    rreg(OFS_FLOW, r);
    check("priv write", r, 32'h0000_0008);
    wreg(OFS_FLOW, 32'h0);
    wreg(OFS_MASTER, 32'h0000_0100);
    bus(1'b1, 1'b1, 1'b1, 32'h0000_0100, 32'hcafe_0001, r);
    bus(1'b1, 1'b1, 1'b0, 32'h0000_0100, 32'hdead_0002, r);
    bus(1'b1, 1'b0, 1'b0, 32'h0000_0100, 32'h0, r);
    check("user ram read", r, 32'h0);
    check("user ram waits", waits, 0);
    bus(1'b1, 1'b0, 1'b1, 32'h0000_0100, 32'h0, r);
    check("priv ram read", r, 32'hcafe_0001);
    check("priv ram waits", waits, 3);
    wreg(OFS_MASTER, 32'h0);
    bus(1'b1, 1'b0, 1'b0, 32'h0000_0100, 32'h0, r);
    check("user ram open", r, 32'hcafe_0001);
    $display("done privilege");
  endtask

  task automatic test_start_stop();
    wreg(OFS_MASTER, 32'h0000_0060);
    start_in = 1'b1;
    repeat (3) @(negedge clock_in);
    start_in = 1'b0;
    rreg(OFS_MASTER, r);
    check("start", r, 32'h8000_0060);
    stop_in = 1'b1;
    repeat (3) @(negedge clock_in);
    stop_in = 1'b0;
    rreg(OFS_MASTER, r);
    check("stop", r, 32'h0000_0060);
    // stop lands on the edge where the writer starts a packet, before either word is written
    wreg(OFS_MASTER, 32'h8000_004b);
    @(negedge clock_in);
    trace_valid_in = 1'b1;
    trace_data_in = 64'h5555_0005_6666_0006;
    @(negedge clock_in);
    trace_valid_in = 1'b0;
    stop_in = 1'b1;
    @(negedge clock_in);
    stop_in = 1'b0;
    repeat (12) @(negedge clock_in);
    check("stop mid packet", u_ram.mem[1], 32'h5555_0005);
    rreg(OFS_POSITION, r);
    check("stop position", r, 32'h0000_0008);
    rreg(OFS_MASTER, r);
    check("stop mid enable", r, 32'h0000_004b);
    wreg(OFS_MASTER, 32'h0);
    $display("done start_stop");
  endtask

  task automatic test_watermark();
    wreg(OFS_POSITION, 32'h0);
    wreg(OFS_FLOW, 32'h0000_0013);
    wreg(OFS_MASTER, 32'h8000_000b);
    send(64'h1111_0001_2222_0002);
    send(64'h3333_0003_4444_0004);
    check("word0", u_ram.mem[0], 32'h2222_0002);
    check("word1", u_ram.mem[1], 32'h1111_0001);
    check("word2", u_ram.mem[2], 32'h4444_0004);
    check("word3", u_ram.mem[3], 32'h3333_0003);
    rreg(OFS_POSITION, r);
    check("position", r, 32'h0000_0010);
    rreg(OFS_MASTER, r);
    check("auto stop halt", r, 32'h0000_020b);
    check("halt gated", halt_out, 1'b0);
    dbg_en = 1'b1;
    repeat (3) @(negedge clock_in);
    check("halt out", halt_out, 1'b1);
    wreg(OFS_MASTER, 32'h0000_002b);
    start_in = 1'b1;
    repeat (3) @(negedge clock_in);
    rreg(OFS_MASTER, r);
    check("start blocked", r[31], 1'b0);
    wreg(OFS_FLOW, 32'h0);
    repeat (2) @(negedge clock_in);
    rreg(OFS_MASTER, r);
    check("start after rewrite", r[31], 1'b1);
    start_in = 1'b0;
    dbg_en = 1'b0;
    wreg(OFS_MASTER, 32'h0);
    $display("done watermark");
  endtask

  task automatic test_wrap();
    logic [4:0] mask [4] = '{5'h00, 5'h02, 5'h1f, 5'h0a};
    logic [11:0] ptr [4] = '{12'h001, 12'h00b, 12'hfff, 12'hfff};
    logic [31:0] pos [4] = '{32'h4, 32'h60, 32'h4, 32'h4004};
    foreach (mask[i])
    begin
      wreg(OFS_POSITION, {17'h0, ptr[i], 3'h0});
      wreg(OFS_MASTER, {27'h400_0000, mask[i]});
      send({32'h6600_0000 + i, 32'h7700_0000 + i});
      wreg(OFS_MASTER, 32'h0);
      rreg(OFS_POSITION, r);
      check("wrap position", r, pos[i]);
      check("wrap word", u_ram.mem[{ptr[i], 1'b0}], 32'h7700_0000 + i);
    end
    $display("done wrap");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clock_in);
    fail_count++;
    tally_and_finish();
  end

  initial
  begin
    repeat (10) @(negedge clock_in);
    sys_rst_in = 1'b0;
    rreg(OFS_MASTER, r);
    check("master reset", r, MASTER_RST);
    test_hardwired();
    test_privilege();
    test_start_stop();
    test_watermark();
    test_wrap();
    tally_and_finish();
  end
endmodule
